// >>> vco_cal_consts.vh
`ifndef VCO_CAL_CONSTS_VH
`define VCO_CAL_CONSTS_VH
// Register word indices (byte address = 4 * index)
`define IDX_CAL_CTRL 12'h018
`define IDX_STATUS 12'h01F
`define IDX_CH0_DIV 12'h190
`define IDX_CH0_BYP 12'h191
`define IDX_CH0_CTRL 12'h192
`define IDX_CH1_DIV 12'h193
`define IDX_CH1_BYP 12'h194
`define IDX_CH1_CTRL 12'h195
`define IDX_CH2_DIV 12'h196
`define IDX_CH2_BYP 12'h197
`define IDX_CH2_CTRL 12'h198
`define IDX_CH0_PHASE 12'h1A0
`define IDX_CH1_PHASE 12'h1A1
`define IDX_CH2_PHASE 12'h1A2
`define IDX_PREDIV 12'h1E0
`define IDX_SRC_SEL 12'h1E1
`define IDX_REF_DIV 12'h1F0
`define IDX_UPDATE 12'h232
`define ADDR_W 14
// Field positions
`define CAL_START_BIT 0
`define CAL_DIV_LO 1
`define STAT_CAL_DONE_BIT 6
`define BYPASS_BIT 7
`define DUTY_FIX_DIS_BIT 0
`define DIRECT_BIT 1
`define PHASE_START_HIGH_BIT 5
`define UPDATE_BIT 0
// Encodings and counts
`define SRC_EXT_PRE 2'h0
`define SRC_EXT_NOPRE 2'h1
`define SRC_OSC_PRE 2'h2
`define CAL_CYCLES 13'h1130
`define PREDIV_MIN 3'h2
`define PREDIV_MAX 3'h6
`define REF_DIV_RESET 8'h01
`define SRC_RESET 2'h2
`define PREDIV_RESET 3'h2
`define DIV_RESET 8'h00
`endif

// >>> chan_divider.v
`timescale 1ns/1ps
`default_nettype none
`include "vco_cal_consts.vh"
module chan_divider (
  // Clock and reset
  input wire clk_in,
  input wire rst_n_in,
  // Settings
  input wire [3:0] low_m_in,
  input wire [3:0] high_n_in,
  input wire bypass_in,
  input wire duty_fix_disable_in,
  input wire [4:0] delay_in,
  input wire start_high_in,
  input wire hold_in,
  input wire tick_in,
  // Output
  output reg div_out
);
  reg [4:0] cnt_q;
  reg [4:0] dly_q;
  reg phase_q;
  reg half_q;
  // Widened so that N = 15 cannot wrap onto M = 0
  wire odd_fix = !duty_fix_disable_in && ({1'b0, low_m_in} == {1'b0, high_n_in} + 5'h01);
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_q <= 5'h00;
      dly_q <= 5'h00;
      phase_q <= 1'b0;
      half_q <= 1'b0;
      div_out <= 1'b0;
    end else if (hold_in) begin
      // Static output while held; restart applies delay and start level
      cnt_q <= 5'h00;
      dly_q <= delay_in;
      phase_q <= start_high_in;
      half_q <= 1'b0;
      div_out <= start_high_in;
    end else if (tick_in) begin
      if (bypass_in) begin
        div_out <= ~div_out;
      end else if (dly_q != 5'h00) begin
        dly_q <= dly_q - 5'h01;
      end else begin
        // High lasts N+1 ticks, low M+1 ticks
        if (cnt_q == {1'b0, (phase_q ? high_n_in : low_m_in)}) begin
          cnt_q <= 5'h00;
          phase_q <= ~phase_q;
          half_q <= phase_q;
        end else begin
          cnt_q <= cnt_q + 5'h01;
          half_q <= 1'b0;
        end
        // Odd correction stretches high by half a tick, modelled as one extra
        div_out <= odd_fix ? (phase_q | half_q) : phase_q;
      end
    end
  end
endmodule // chan_divider
`default_nettype wire

// >>> vco_cal_and_clock_distribution.v
// Contract
// - Calibration sequencer advances only on divided reference clock ticks.
// - Status bit reads 1 once calibration has finished.
// - Calibration asserts output hold; releases it when calibration ends.
// - Calibration clock is phase detector clock over two-bit selected divisor.
// - Calibration lasts 4400 calibration clock cycles.
// - Calibration starts only on explicit software request, never on divider change.
// - Channel divider divides 2 to 32 or bypasses for one.
// - Pre-divider divides 2 to 6, always used with oscillator source.
// - Output high N+1 and low M+1 input cycles.
// - Disableable duty fix; odd division corrected only when M equals N+1.
// - Coarse delay up to 31 cycles and selectable start level.
// - Source field: 00 ext+pre, 01 ext direct, 10 osc+pre, 11 illegal.
// - Direct-route bits pass pre-divider input to the output pair; the code honours them only with source 00 or 10.
// - Low and high cycle fields hold count minus one.
//
// Design decision made here: register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
`include "vco_cal_consts.vh"
module vco_cal_and_clock_distribution (
  // Clock and reset
  input wire clock_in,
  input wire rstn_in,
  // Avalon-MM slave
  input wire [`ADDR_W-1:0] address_in,
  input wire read_in,
  input wire write_in,
  input wire [31:0] writedata_in,
  output reg [31:0] readdata_out,
  output wire waitrequest_out,
  // Clock sources (sampled edges of slow test clocks)
  input wire reference_input_in,
  input wire ext_clock_in,
  input wire osc_clock_in,
  // Status and outputs
  output wire output_hold_out,
  output wire [2:0] output_pair_first_out
);
  reg rst_s1_q, rst_n_q;
  always @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rst_s1_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q <= rst_s1_q;
    end
  end

  // Two-stage synchronisers for the pin clocks
  reg [2:0] pin_s1_q, pin_s2_q, pin_s3_q;
  always @(posedge clock_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      pin_s1_q <= 3'h0;
      pin_s2_q <= 3'h0;
      pin_s3_q <= 3'h0;
    end else begin
      pin_s1_q <= {osc_clock_in, ext_clock_in, reference_input_in};
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end
  wire [2:0] rise = pin_s2_q & ~pin_s3_q;
  wire ref_tick = rise[0];

  // Shadow and active registers; writes land in shadow, update copies them
  reg [7:0] cal_ctrl_sh_q, cal_ctrl_q;
  reg [7:0] div_sh_q [0:2];
  reg [7:0] byp_sh_q [0:2];
  reg [7:0] ctl_sh_q [0:2];
  reg [7:0] ph_sh_q [0:2];
  reg [7:0] div_q [0:2];
  reg [7:0] byp_q [0:2];
  reg [7:0] ctl_q [0:2];
  reg [7:0] ph_q [0:2];
  reg [2:0] prediv_sh_q, prediv_q;
  reg [1:0] src_sh_q, src_q;
  reg [7:0] ref_div_sh_q, ref_div_q;
  reg cal_done_q;
  reg cal_busy_q;

  function [11:0] word_index;
    input [`ADDR_W-1:0] a;
    word_index = a[`ADDR_W-1:2];
  endfunction

  function [2:0] clamp_prediv;
    input [2:0] v;
    clamp_prediv = (v < `PREDIV_MIN) ? `PREDIV_MIN : ((v > `PREDIV_MAX) ? `PREDIV_MAX : v);
  endfunction

  wire [11:0] idx = word_index(address_in);
  // Reads take one wait state so that the data stand registered at the accept edge
  reg rd_ack_q;
  assign waitrequest_out = read_in && !rd_ack_q;
  wire wr = write_in;
  wire update_req = wr && (idx == `IDX_UPDATE) && writedata_in[`UPDATE_BIT];

  integer i;
  always @(posedge clock_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      cal_ctrl_sh_q <= 8'h00;
      cal_ctrl_q <= 8'h00;
      prediv_sh_q <= `PREDIV_RESET;
      prediv_q <= `PREDIV_RESET;
      src_sh_q <= `SRC_RESET;
      src_q <= `SRC_RESET;
      ref_div_sh_q <= `REF_DIV_RESET;
      ref_div_q <= `REF_DIV_RESET;
      for (i = 0; i < 3; i = i + 1) begin
        div_sh_q[i] <= `DIV_RESET;
        byp_sh_q[i] <= 8'h00;
        ctl_sh_q[i] <= 8'h00;
        ph_sh_q[i] <= 8'h00;
        div_q[i] <= `DIV_RESET;
        byp_q[i] <= 8'h00;
        ctl_q[i] <= 8'h00;
        ph_q[i] <= 8'h00;
      end
    end else begin
      if (wr) begin
        case (idx)
          `IDX_CAL_CTRL: cal_ctrl_sh_q <= writedata_in[7:0];
          `IDX_CH0_DIV: div_sh_q[0] <= writedata_in[7:0];
          `IDX_CH1_DIV: div_sh_q[1] <= writedata_in[7:0];
          `IDX_CH2_DIV: div_sh_q[2] <= writedata_in[7:0];
          `IDX_CH0_BYP: byp_sh_q[0] <= writedata_in[7:0];
          `IDX_CH1_BYP: byp_sh_q[1] <= writedata_in[7:0];
          `IDX_CH2_BYP: byp_sh_q[2] <= writedata_in[7:0];
          `IDX_CH0_CTRL: ctl_sh_q[0] <= writedata_in[7:0];
          `IDX_CH1_CTRL: ctl_sh_q[1] <= writedata_in[7:0];
          `IDX_CH2_CTRL: ctl_sh_q[2] <= writedata_in[7:0];
          `IDX_CH0_PHASE: ph_sh_q[0] <= writedata_in[7:0];
          `IDX_CH1_PHASE: ph_sh_q[1] <= writedata_in[7:0];
          `IDX_CH2_PHASE: ph_sh_q[2] <= writedata_in[7:0];
          `IDX_PREDIV: prediv_sh_q <= clamp_prediv(writedata_in[2:0]);
          `IDX_SRC_SEL: src_sh_q <= writedata_in[1:0];
          `IDX_REF_DIV: ref_div_sh_q <= writedata_in[7:0];
          default: ;
        endcase
      end
      if (update_req) begin
        cal_ctrl_q <= cal_ctrl_sh_q;
        prediv_q <= prediv_sh_q;
        // Illegal source code keeps the previous selection
        if (src_sh_q != 2'h3) src_q <= src_sh_q;
        ref_div_q <= (ref_div_sh_q == 8'h00) ? `REF_DIV_RESET : ref_div_sh_q;
        for (i = 0; i < 3; i = i + 1) begin
          div_q[i] <= div_sh_q[i];
          byp_q[i] <= byp_sh_q[i];
          ctl_q[i] <= ctl_sh_q[i];
          ph_q[i] <= ph_sh_q[i];
        end
      end
    end
  end

  // Start request: rising edge of the active start bit only
  reg start_prev_q;
  wire start_now = cal_ctrl_q[`CAL_START_BIT] && !start_prev_q;

  // Divided reference: phase detector tick, then calibration divisor tick
  reg [7:0] rdiv_cnt_q;
  reg [3:0] cdiv_cnt_q;
  reg [12:0] cal_cnt_q;
  wire pfd_tick = ref_tick && (rdiv_cnt_q == ref_div_q - 8'h01);
  wire [3:0] cal_div = 4'h2 << cal_ctrl_q[`CAL_DIV_LO +: 2];
  wire cal_tick = pfd_tick && (cdiv_cnt_q == cal_div - 4'h1);

  always @(posedge clock_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      start_prev_q <= 1'b0;
      rdiv_cnt_q <= 8'h00;
      cdiv_cnt_q <= 4'h0;
      cal_cnt_q <= 13'h0000;
      cal_busy_q <= 1'b0;
      cal_done_q <= 1'b0;
    end else begin
      start_prev_q <= cal_ctrl_q[`CAL_START_BIT];
      if (ref_tick) begin
        rdiv_cnt_q <= pfd_tick ? 8'h00 : rdiv_cnt_q + 8'h01;
      end
      if (start_now) begin
        cal_busy_q <= 1'b1;
        cal_done_q <= 1'b0;
        cal_cnt_q <= 13'h0000;
        cdiv_cnt_q <= 4'h0;
      end else if (cal_busy_q && pfd_tick) begin
        cdiv_cnt_q <= cal_tick ? 4'h0 : cdiv_cnt_q + 4'h1;
        if (cal_tick) begin
          if (cal_cnt_q == `CAL_CYCLES - 13'h0001) begin
            cal_busy_q <= 1'b0;
            cal_done_q <= 1'b1;
          end else begin
            cal_cnt_q <= cal_cnt_q + 13'h0001;
          end
        end
      end
    end
  end
  assign output_hold_out = cal_busy_q;

  // Distribution source and pre-divider
  wire src_osc = (src_q == `SRC_OSC_PRE);
  wire use_pre = src_osc || (src_q == `SRC_EXT_PRE);
  wire src_rise = src_osc ? rise[2] : rise[1];
  reg [2:0] pre_cnt_q;
  wire pre_tick = src_rise && (pre_cnt_q == prediv_q - 3'h1);
  always @(posedge clock_in or negedge rst_n_q) begin
    if (!rst_n_q) pre_cnt_q <= 3'h0;
    else if (src_rise) pre_cnt_q <= pre_tick ? 3'h0 : pre_cnt_q + 3'h1;
  end
  wire div_tick = use_pre ? pre_tick : src_rise;
  wire src_level = src_osc ? pin_s3_q[2] : pin_s3_q[1];
  // Bypassed channels follow the divider input itself: divide by one
  wire pre_level = (pre_cnt_q < (prediv_q >> 1));
  wire byp_level = use_pre ? pre_level : src_level;

  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : chan
      wire div_o;
      chan_divider u_div (
        .clk_in(clock_in),
        .rst_n_in(rst_n_q),
        .low_m_in(div_q[g][7:4]),
        .high_n_in(div_q[g][3:0]),
        .bypass_in(byp_q[g][`BYPASS_BIT]),
        .duty_fix_disable_in(ctl_q[g][`DUTY_FIX_DIS_BIT]),
        .delay_in(ph_q[g][4:0]),
        .start_high_in(ph_q[g][`PHASE_START_HIGH_BIT]),
        .hold_in(cal_busy_q),
        .tick_in(div_tick),
        .div_out(div_o)
      );
      // Direct route only honoured with the pre-divider in the path
      assign output_pair_first_out[g] = cal_busy_q ? div_o :
                                        (ctl_q[g][`DIRECT_BIT] && use_pre) ? src_level :
                                        byp_q[g][`BYPASS_BIT] ? byp_level : div_o;
    end
  endgenerate

  // Read path: data registered in the wait cycle, standing at the accept edge
  always @(posedge clock_in or negedge rst_n_q) begin
    if (!rst_n_q) rd_ack_q <= 1'b0;
    else rd_ack_q <= read_in && !rd_ack_q;
  end
  always @(posedge clock_in or negedge rst_n_q) begin
    if (!rst_n_q) readdata_out <= 32'h00000000;
    else if (read_in && !rd_ack_q) begin
      case (idx)
        `IDX_CAL_CTRL: readdata_out <= {24'h000000, cal_ctrl_sh_q};
        `IDX_STATUS: readdata_out <= {24'h000000, 1'b0, cal_done_q, 6'h00};
        `IDX_CH0_DIV: readdata_out <= {24'h000000, div_sh_q[0]};
        `IDX_CH1_DIV: readdata_out <= {24'h000000, div_sh_q[1]};
        `IDX_CH2_DIV: readdata_out <= {24'h000000, div_sh_q[2]};
        `IDX_CH0_BYP: readdata_out <= {24'h000000, byp_sh_q[0]};
        `IDX_CH1_BYP: readdata_out <= {24'h000000, byp_sh_q[1]};
        `IDX_CH2_BYP: readdata_out <= {24'h000000, byp_sh_q[2]};
        `IDX_CH0_CTRL: readdata_out <= {24'h000000, ctl_sh_q[0]};
        `IDX_CH1_CTRL: readdata_out <= {24'h000000, ctl_sh_q[1]};
        `IDX_CH2_CTRL: readdata_out <= {24'h000000, ctl_sh_q[2]};
        `IDX_CH0_PHASE: readdata_out <= {24'h000000, ph_sh_q[0]};
        `IDX_CH1_PHASE: readdata_out <= {24'h000000, ph_sh_q[1]};
        `IDX_CH2_PHASE: readdata_out <= {24'h000000, ph_sh_q[2]};
        `IDX_PREDIV: readdata_out <= {29'h00000000, prediv_sh_q};
        `IDX_SRC_SEL: readdata_out <= {30'h00000000, src_sh_q};
        `IDX_REF_DIV: readdata_out <= {24'h000000, ref_div_sh_q};
        default: readdata_out <= 32'h00000000;
      endcase
    end
  end
endmodule // vco_cal_and_clock_distribution
`default_nettype wire

// >>> vco_cal_monitor.sv
`timescale 1ns/1ps
`default_nettype none
`include "vco_cal_consts.vh"
module vco_cal_monitor (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rstn_in,
  // Register bus
  input wire logic [13:0] address_in,
  input wire logic read_in,
  input wire logic write_in,
  input wire logic [31:0] readdata_out,
  input wire logic waitrequest_out,
  // Sources and outputs
  input wire logic reference_input_in,
  input wire logic output_hold_out,
  input wire logic [2:0] output_pair_first_out
);
  logic ref_q;
  logic done_q;
  logic [31:0] edges_q;
  logic [3:0] upd_q;
  wire upd_wr = write_in && !waitrequest_out && address_in[13:2] == `IDX_UPDATE;
  wire st_rd = read_in && !waitrequest_out && address_in[13:2] == `IDX_STATUS;
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rstn_in);
  always @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ref_q <= 1'b0;
      done_q <= 1'b0;
      edges_q <= 32'h0;
      upd_q <= 4'hF;
    end else begin
      ref_q <= reference_input_in;
      edges_q <= !output_hold_out ? 32'h0 : edges_q + {31'h0, reference_input_in && !ref_q};
      upd_q <= upd_wr ? 4'h0 : (upd_q == 4'hF ? 4'hF : upd_q + 4'h1);
      done_q <= $fell(output_hold_out) ? 1'b1 : (output_hold_out ? 1'b0 : done_q);
    end
  end
  // Only a fresh update strobe may open a calibration
  chk_start_cause: assert property ($rose(output_hold_out) |-> upd_q <= 4'h4)
    else $error("hold rose without an update strobe");
  chk_cal_length: assert property ($fell(output_hold_out) |-> edges_q >= 32'd8790)
    else $error("calibration ended too early");
  chk_ref_needed: assert property ((output_hold_out && $stable(reference_input_in))[*8]
    |=> output_hold_out)
    else $error("calibration ended without reference edges");
  chk_outputs_static: assert property (output_hold_out && $past(output_hold_out, 2)
    |-> $stable(output_pair_first_out))
    else $error("outputs moved during hold");
  chk_busy_reads_zero: assert property (st_rd && output_hold_out |=> !readdata_out[6])
    else $error("done read high during calibration");
  chk_done_reads_one: assert property (st_rd && done_q && !output_hold_out
    |=> readdata_out[6])
    else $error("done read low after calibration");
  chk_write_no_wait: assert property (write_in |-> !waitrequest_out)
    else $error("write stalled");
  chk_read_stands: assert property (!read_in |=> $stable(readdata_out))
    else $error("read data changed without a read");
endmodule // vco_cal_monitor
bind vco_cal_and_clock_distribution vco_cal_monitor mon (.clock_in(clock_in),
  .rstn_in(rstn_in), .address_in(address_in), .read_in(read_in), .write_in(write_in),
  .readdata_out(readdata_out), .waitrequest_out(waitrequest_out),
  .reference_input_in(reference_input_in), .output_hold_out(output_hold_out),
  .output_pair_first_out(output_pair_first_out));
`default_nettype wire

// >>> vco_cal_and_clock_distribution_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "vco_cal_consts.vh"
module vco_cal_and_clock_distribution_tb_top;
  logic clock_in, rstn_in, read_in, write_in, ref_run;
  logic reference_input_in, ext_clock_in, osc_clock_in;
  logic [13:0] address_in;
  logic [31:0] writedata_in, rd;
  wire [31:0] readdata_out;
  wire waitrequest_out, output_hold_out;
  wire [2:0] output_pair_first_out;
  int ref_half, rc, mismatches, samples_checked;
  // Source 00 and 10 use the pre-divider (reset value 2)
  logic [7:0] src [5] = '{8'h01, 8'h01, 8'h00, 8'h00, 8'h02};
  logic [7:0] byp [5] = '{8'h00, 8'h80, 8'h00, 8'h00, 8'h00};
  logic [7:0] ctl [5] = '{8'h01, 8'h01, 8'h01, 8'h03, 8'h01};
  int hi [5] = '{4, 2, 8, 2, 4};
  int lo [5] = '{12, 2, 24, 2, 12};
  vco_cal_and_clock_distribution uut (.clock_in(clock_in), .rstn_in(rstn_in),
    .address_in(address_in), .read_in(read_in), .write_in(write_in),
    .writedata_in(writedata_in), .readdata_out(readdata_out),
    .waitrequest_out(waitrequest_out), .reference_input_in(reference_input_in),
    .ext_clock_in(ext_clock_in), .osc_clock_in(osc_clock_in),
    .output_hold_out(output_hold_out), .output_pair_first_out(output_pair_first_out));
  initial begin
    clock_in = 1'b0;
    forever #12.5 clock_in = ~clock_in;
  end
  // External clock has a 4-cycle period; reference rate is set per test
  always @(posedge clock_in) begin
    osc_clock_in <= ~osc_clock_in;
    if (osc_clock_in) ext_clock_in <= ~ext_clock_in;
    if (ref_run && rc >= ref_half - 1) begin
      reference_input_in <= ~reference_input_in;
      rc <= 0;
    end else if (ref_run) rc <= rc + 1;
  end
  task summarize;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask
  task bus(input logic wr, input logic [11:0] idx, input logic [7:0] d);
    address_in <= {idx, 2'b00};
    write_in <= wr;
    read_in <= !wr;
    writedata_in <= {24'h0, d};
    @(posedge clock_in);
    while (waitrequest_out !== 1'b0) @(posedge clock_in);
    rd = readdata_out;
    read_in <= 1'b0;
    write_in <= 1'b0;
    @(posedge clock_in);
  endtask
  task start_cal(input logic [7:0] c);
    bus(1'b1, `IDX_CAL_CTRL, c);
    bus(1'b1, `IDX_UPDATE, 8'h01);
    repeat (3) @(posedge clock_in);
    chk({31'h0, output_hold_out}, 1, "hold not raised");
    bus(1'b0, `IDX_STATUS, 8'h00);
    chk({31'h0, rd[6]}, 0, "done high while calibrating");
  endtask
  // The reference is paused mid-run; paused cycles are not counted
  task run_cal(input int exp);
    int n, k;
    n = 0;
    k = 0;
    while (output_hold_out === 1'b1 && k < 80000) begin
      @(posedge clock_in);
      k++;
      if (ref_run) n++;
      if (k == 1000) ref_run <= 1'b0;
      if (k == 1400) chk({31'h0, output_hold_out}, 1, "ended without reference");
      if (k == 1400) ref_run <= 1'b1;
    end
    chk({31'h0, n > exp - 16 && n < exp + 16}, 1, "calibration length");
    bus(1'b0, `IDX_STATUS, 8'h00);
    chk({31'h0, rd[6]}, 1, "done not set");
    $display("calibration test finished");
  endtask
  task measure(input int eh, input int el);
    int h, l, k;
    h = 0;
    l = 0;
    for (k = 0; output_pair_first_out[0] !== 1'b0 && k < 300; k++) @(posedge clock_in);
    for (k = 0; output_pair_first_out[0] !== 1'b1 && k < 300; k++) @(posedge clock_in);
    for (h = 0; output_pair_first_out[0] === 1'b1 && h < 300; h++) @(posedge clock_in);
    for (l = 0; output_pair_first_out[0] === 1'b0 && l < 300; l++) @(posedge clock_in);
    chk(h, eh, "high time");
    chk(l, el, "low time");
  endtask
  initial begin
    repeat (90000) @(posedge clock_in);
    mismatches++;
    $display("CHECK FAILED at %0t: watchdog", $time);
    summarize;
  end
  initial begin
    {rstn_in, read_in, write_in, reference_input_in, ext_clock_in, osc_clock_in} = 6'h00;
    address_in = 14'h0000;
    writedata_in = 32'h0;
    ref_run = 1'b1;
    ref_half = 2;
    rc = 0;
    mismatches = 0;
    samples_checked = 0;
    repeat (8) @(posedge clock_in);
    rstn_in <= 1'b1;
    repeat (3) @(posedge clock_in);
    bus(1'b1, `IDX_REF_DIV, 8'h01);
    bus(1'b1, `IDX_CH0_DIV, 8'h11);
    bus(1'b1, `IDX_UPDATE, 8'h01);
    repeat (20) @(posedge clock_in);
    chk({31'h0, output_hold_out}, 0, "calibration started alone");
    $display("idle test finished");
    start_cal(8'h01);
    run_cal(35200);
    bus(1'b1, `IDX_CAL_CTRL, 8'h00);
    bus(1'b1, `IDX_UPDATE, 8'h01);
    ref_half <= 1;
    start_cal(8'h03);
    run_cal(35200);
    for (int i = 0; i < 5; i++) begin
      bus(1'b1, `IDX_SRC_SEL, src[i]);
      bus(1'b1, `IDX_CH0_DIV, 8'h20);
      bus(1'b1, `IDX_CH0_BYP, byp[i]);
      bus(1'b1, `IDX_CH0_CTRL, ctl[i]);
      bus(1'b1, `IDX_UPDATE, 8'h01);
      bus(1'b0, `IDX_CH0_DIV, 8'h00);
      chk(rd, 32'h0000_0020, "divider readback");
      repeat (40) @(posedge clock_in);
      measure(hi[i], lo[i]);
    end
    $display("channel test finished");
    bus(1'b0, 12'hFFF, 8'h00);
    chk(rd, 32'h0, "unmapped read");
    summarize;
  end
endmodule // vco_cal_and_clock_distribution_tb_top
`default_nettype wire
